/* File: rtl/wdg_pkg.sv */
package wdg_pkg;

  // clock and slow-source rates
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_HZ        = 25_000_000;
  localparam int SLOW_RC_HZ    = 32_000;
  // cycles of pclk per low-speed rc tick, rounded down
  localparam int SLOW_RC_DIV   = CLK_HZ / SLOW_RC_HZ;

  // start delays, figures as given, then as pclk cycles (least, round up)
  localparam int RSTD_POR_NS   = 50_000_000;
  localparam int RSTD_WDT_NS   = 16_700_000;
  localparam int SRESET_NS     = 100_000;
  localparam int POR_DLY_CYC   = (RSTD_POR_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int WDT_DLY_CYC   = (RSTD_WDT_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int SRESET_CYC    = (SRESET_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int DLY_W         = 21;

  // watchdog counter shape
  localparam int WDT_W         = 15;
  localparam int WS_BASE       = 8;

  // register byte addresses
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_RCF      = 12'h004;
  localparam logic [11:0] ADDR_STAT     = 12'h008;
  localparam logic [11:0] ADDR_INT_STAT = 12'h00C;
  localparam logic [11:0] ADDR_INT_MASK = 12'h010;

  // watchdog_control layout and power-on value
  localparam logic [7:0] CTRL_RESET  = 8'h53;
  localparam int         KEY_LSB     = 3;
  localparam int         KEY_MSB     = 7;
  localparam int         SEL_MSB     = 2;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [4:0] KEY_ENABLE  = 5'h0A;

  // interrupt status and mask bits
  localparam int INT_W         = 3;
  localparam int INT_OVF_RUN   = 0;
  localparam int INT_OVF_SLEEP = 1;
  localparam int INT_KEY       = 2;

  typedef enum logic [2:0] {
    ST_POR_WAIT,
    ST_RUN,
    ST_SLEEP,
    ST_KEY_WAIT,
    ST_RST_WAIT
  } wdg_state_t;

  typedef struct packed {
    logic key_reset;
    logic powerdown;
    logic timeout;
  } wdg_flags_t;

endpackage

/* File: rtl/wdg_tick_div.sv */
`timescale 1ns/1ps
module wdg_tick_div #(
  parameter int DIV = 781
) (
  input  logic pclk,
  input  logic presetn,
  output logic tick
);
  logic [15:0] cnt_reg;

  if (DIV < 2 || DIV > 65536) begin : g_chk
    $error("wdg_tick_div: DIV out of range");
  end

  // count pclk cycles, emit one-cycle enable per slow period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
      tick    <= 1'b0;
    end else if (cnt_reg == 16'(DIV - 1)) begin
      cnt_reg <= 16'h0000;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick    <= 1'b0;
    end
  end
endmodule // wdg_tick_div

/* File: rtl/wdg_counter.sv */
`timescale 1ns/1ps
module wdg_counter #(
  parameter int WIDTH = 15,
  parameter int BASE  = 8
) (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       tick,
  input  logic       run,
  input  logic       clear,
  input  logic [2:0] sel,
  output logic       overflow
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] lim;

  if (WIDTH < BASE + 7 || BASE < 1) begin : g_chk
    $error("wdg_counter: WIDTH too small for selectable ratios");
  end

  // ones in the low BASE+sel bits mark the last count before rollover
  assign lim = {WIDTH{1'b1}} >> (5'(WIDTH - BASE) - {2'b00, sel});

  // free-running binary count; clear has priority over the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= '0;
      overflow <= 1'b0;
    end else if (clear) begin
      cnt_reg  <= '0;
      overflow <= 1'b0;
    end else if (run && tick && ((cnt_reg & lim) == lim)) begin
      cnt_reg  <= '0;
      overflow <= 1'b1;
    end else begin
      if (run && tick) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      overflow <= 1'b0;
    end
  end

  // overflow only ever follows a slow tick
  a_ovf_on_tick: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |-> $past(tick)) // RQ18
    else $error("overflow without slow tick");
endmodule // wdg_counter

/* File: rtl/wdg_ctrl.sv */
// How it works
// RQ1: counter ticks from slow rc clock; select picks two^8 to two^15.
// RQ2: key field at disable pattern stops the watchdog.
// RQ3: key field at enable pattern lets the watchdog count.
// RQ4: any other key value resets the device after a soft delay.
// RQ5: that key-caused reset sets the key reset flag bit zero.
// RQ6: key reset flag set by hardware only, cleared only by writing zero.
// RQ7: after power-on the key field holds the enable pattern.
// RQ8: overflow while running gives full reset and sets timeout flag.
// RQ9: overflow while asleep sets timeout, clears only pc and stack.
// RQ10: counter cleared by key reset, halt, or clear instruction.
// RQ11: flags encode cause: power-on, running timeout, sleeping timeout.
// RQ12: power-on reset holds the chip reset, pc to zero, watchdog restarts.
// RQ13: running timeout reloads control registers; sleep timeout keeps them.
// RQ14: upper seven bits of key reset flag register read zero.
// RQ15: start delay 50 ms after power-on, 16.7 ms after timeout.
// RQ16: halt sets powerdown flag; clear instruction clears it.
// RQ17: halt clears the counter, which keeps running only if enabled.
// RQ18: counter is a binary count; selected bit rollover is overflow.
`timescale 1ns/1ps
module wdg_ctrl
  import wdg_pkg::*;
#(
  parameter int POR_DLY    = wdg_pkg::POR_DLY_CYC,
  parameter int WDT_DLY    = wdg_pkg::WDT_DLY_CYC,
  parameter int SRESET_DLY = wdg_pkg::SRESET_CYC,
  parameter int SLOW_DIV   = wdg_pkg::SLOW_RC_DIV
) (
  input  logic               pclk,
  input  logic               presetn,
  input  logic               psel,
  input  logic               penable,
  input  logic               pwrite,
  input  logic [11:0]        paddr,
  input  logic [31:0]        pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  logic               clear_wdt_instr,
  input  logic               halt_instr,
  input  logic               wake_req,
  output logic               sys_reset,
  output logic               pc_sp_clear,
  output logic               sleeping,
  output wdg_pkg::wdg_flags_t cause_flags,
  output logic               irq
);
  import wdg_pkg::*;

  wdg_state_t        state_reg;
  wdg_state_t        state_next;
  logic [DLY_W-1:0]  dly_reg;
  logic [7:0]        ctrl_reg;
  logic              rcf_reg;
  logic              timeout_reg;
  logic              powerdown_reg;
  logic [INT_W-1:0]  int_stat_reg;
  logic [INT_W-1:0]  int_mask_reg;
  logic [4:0]        key;
  logic              key_bad;
  logic              awake;
  logic              tick;
  logic              ovf;
  logic              ovf_run;
  logic              ovf_sleep;
  logic              key_fire;
  logic              halt_take;
  logic              clr_take;
  logic              cnt_run;
  logic              cnt_clear;
  logic              acc;
  logic              wr_en;
  logic              rd_hit;
  logic [31:0]       rd_data;
  logic [INT_W-1:0]  int_events;

  if (POR_DLY < 1 || WDT_DLY < 1 || SRESET_DLY < 1 ||
      POR_DLY > 2**DLY_W || WDT_DLY > 2**DLY_W ||
      SRESET_DLY > 2**DLY_W) begin : g_chk
    $error("wdg_ctrl: delay counts out of range");
  end

  // slow rc tick as an enable on the single pclk domain
  // RQ1: slow clock source
  wdg_tick_div #(
    .DIV (SLOW_DIV)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // RQ18: binary watchdog count
  wdg_counter #(
    .WIDTH (WDT_W),
    .BASE  (WS_BASE)
  ) u_cnt (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick),
    .run      (cnt_run),
    .clear    (cnt_clear),
    .sel      (ctrl_reg[SEL_MSB:0]),
    .overflow (ovf)
  );

  // decoded events; key checked continuously so corruption is caught too
  assign key       = ctrl_reg[KEY_MSB:KEY_LSB];
  assign awake     = (state_reg == ST_RUN) || (state_reg == ST_SLEEP);
  // RQ4: illegal key detection
  assign key_bad   = awake && (key != KEY_ENABLE) && (key != KEY_DISABLE);
  assign key_fire  = (state_reg == ST_KEY_WAIT) && (dly_reg == '0);
  assign ovf_run   = (state_reg == ST_RUN) && ovf && !key_bad;
  assign ovf_sleep = (state_reg == ST_SLEEP) && ovf && !key_bad;
  assign halt_take = (state_reg == ST_RUN) && halt_instr && !key_bad &&
                     !ovf;
  assign clr_take  = (state_reg == ST_RUN) && clear_wdt_instr;

  // RQ2: disabled key stops counting
  // RQ3: enabled key counts while awake or asleep
  assign cnt_run   = awake && (key == KEY_ENABLE);
  // RQ10: counter clear sources
  // RQ17: halt clears the count
  assign cnt_clear = !awake || clr_take || halt_take;
  // sequencing of resets, sleep and start delays
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_POR_WAIT: begin
        if (dly_reg == '0) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (key_bad) begin
          state_next = ST_KEY_WAIT;
        end else if (ovf) begin
          state_next = ST_RST_WAIT;
        end else if (halt_instr) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (key_bad) begin
          state_next = ST_KEY_WAIT;
        end else if (ovf || wake_req) begin
          state_next = ST_RUN;
        end
      end
      ST_KEY_WAIT: begin
        if (dly_reg == '0) begin
          state_next = ST_RST_WAIT;
        end
      end
      ST_RST_WAIT: begin
        if (dly_reg == '0) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_POR_WAIT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_POR_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end
  // delay counter, loaded on entry to each waiting state
  // RQ15: power-on and timeout start delays
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_reg <= DLY_W'(POR_DLY - 1);
    end else if (state_next != state_reg &&
                 state_next == ST_RST_WAIT) begin
      dly_reg <= DLY_W'(WDT_DLY - 1);
    end else if (state_next != state_reg &&
                 state_next == ST_KEY_WAIT) begin
      dly_reg <= DLY_W'(SRESET_DLY - 1);
    end else if (dly_reg != '0) begin
      dly_reg <= dly_reg - 1'b1;
    end
  end
  // apb: one wait state, so read data is a clean flop when pready rises
  assign acc   = psel && penable;
  assign wr_en = acc && pready && pwrite;
  // address decode of read data; unmapped addresses flag an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (paddr == ADDR_CTRL) begin
      rd_data[7:0] = ctrl_reg;
    // RQ14: upper bits read zero
    end else if (paddr == ADDR_RCF) begin
      rd_data[0] = rcf_reg;
    end else if (paddr == ADDR_STAT) begin
      rd_data[1:0] = {powerdown_reg, timeout_reg};
    end else if (paddr == ADDR_INT_STAT) begin
      rd_data[INT_W-1:0] = int_stat_reg;
    end else if (paddr == ADDR_INT_MASK) begin
      rd_data[INT_W-1:0] = int_mask_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (acc && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : rd_data;
      pslverr <= !rd_hit;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
  // control register; reloads on a full watchdog or key reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RQ7: enable pattern at power-on
      ctrl_reg <= CTRL_RESET;
    // RQ13: full resets reload control
    end else if (ovf_run || key_fire) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_en && paddr == ADDR_CTRL) begin
      ctrl_reg <= pwdata[7:0];
    end
  end
  // key reset flag: survives every reset but power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcf_reg <= 1'b0;
    // RQ5: key reset sets flag
    end else if (key_fire) begin
      rcf_reg <= 1'b1;
    // RQ6: only a software zero clears it
    end else if (wr_en && paddr == ADDR_RCF && !pwdata[0]) begin
      rcf_reg <= 1'b0;
    end
  end
  // timeout flag: set wins over halt or clear instruction
  // RQ11: cause encoding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_reg <= 1'b0;
    // RQ8: running overflow sets it
    // RQ9: sleeping overflow sets it
    end else if (ovf_run || ovf_sleep) begin
      timeout_reg <= 1'b1;
    end else if (halt_take || clr_take) begin
      timeout_reg <= 1'b0;
    end
  end
  // powerdown flag kept across watchdog resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerdown_reg <= 1'b0;
    // RQ16: halt sets, clear instruction clears
    end else if (halt_take) begin
      powerdown_reg <= 1'b1;
    end else if (clr_take) begin
      powerdown_reg <= 1'b0;
    end
  end
  // reset outputs to the core; chip reset holds pc at zero, irqs off,
  // timer off and ports as inputs for its whole length
  // RQ12: power-on reset outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset <= 1'b1;
    end else begin
      sys_reset <= (state_next == ST_POR_WAIT) ||
                   (state_next == ST_RST_WAIT);
    end
  end
  // RQ9: sleep overflow clears only pc and stack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_sp_clear <= 1'b0;
      sleeping    <= 1'b0;
    end else begin
      pc_sp_clear <= ovf_sleep;
      sleeping    <= (state_next == ST_SLEEP);
    end
  end

  assign cause_flags = '{key_reset: rcf_reg, powerdown: powerdown_reg,
                         timeout: timeout_reg};

  // sticky interrupt status, write one to clear, new event wins
  assign int_events = {key_fire, ovf_sleep, ovf_run};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= '0;
    end else if (wr_en && paddr == ADDR_INT_STAT) begin
      int_stat_reg <= (int_stat_reg & ~pwdata[INT_W-1:0]) | int_events;
    end else begin
      int_stat_reg <= int_stat_reg | int_events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_reg <= '0;
    end else if (wr_en && paddr == ADDR_INT_MASK) begin
      int_mask_reg <= pwdata[INT_W-1:0];
    end
  end

  // one cycle behind status; keeps irq a clean flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_full_reset;
    sys_reset && timeout_reg && (ctrl_reg == CTRL_RESET);
  endsequence
  sequence s_sleep_wake;
    pc_sp_clear && timeout_reg && powerdown_reg && !sys_reset;
  endsequence
  a_key_bad_wait: assert property ( // RQ4
    key_bad |=> (state_reg == ST_KEY_WAIT) && !sys_reset)
    else $error("illegal key did not start soft delay");
  a_key_flag_set: assert property ( // RQ5
    key_fire |=> rcf_reg ##1 sys_reset)
    else $error("key reset did not set flag then reset");
  a_key_flag_hold: assert property ( // RQ6
    rcf_reg && !(wr_en && paddr == ADDR_RCF && !pwdata[0]) |=> rcf_reg)
    else $error("key reset flag lost");
  a_disable_stop: assert property ( // RQ2
    (key == KEY_DISABLE) |-> !cnt_run)
    else $error("counter runs while disabled");
  a_enable_count: assert property ( // RQ3
    (key == KEY_ENABLE) && awake |-> cnt_run)
    else $error("counter stopped while enabled");
  a_run_timeout: assert property ( // RQ8
    ovf_run |=> s_full_reset)
    else $error("running overflow missed full reset");
  a_sleep_timeout: assert property ( // RQ9
    ovf_sleep |=> s_sleep_wake)
    else $error("sleep overflow handled wrongly");
  a_halt_flags: assert property ( // RQ16
    halt_take |=> powerdown_reg && !timeout_reg && sleeping)
    else $error("halt flags wrong");
  a_rst_delay_hold: assert property ( // RQ15
    (state_reg == ST_RST_WAIT) && (dly_reg > 8) |=> sys_reset [*8])
    else $error("reset delay released early");
  a_rcf_upper_zero: assert property ( // RQ14
    acc && !pready && !pwrite && paddr == ADDR_RCF |=>
      pready && (prdata[31:1] == 31'h0000_0000))
    else $error("reset flag upper bits not zero");
endmodule // wdg_ctrl

/* File: verification/wdg_core_model.sv */
`timescale 1ns/1ps
// core stand-in: clear and halt pulses of one cycle each
module wdg_core_model #(
  parameter int KICK = 300
) (
  input  logic pclk,
  input  logic presetn,
  input  logic kick_en,
  input  logic clr_cmd,
  input  logic halt_cmd,
  input  logic wake_cmd,
  output logic clear_wdt_instr,
  output logic halt_instr,
  output logic wake_req
);
  int cnt;

  // kick period sits well inside the shortest timeout
  // clear before overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt             <= 0;
      clear_wdt_instr <= 1'b0;
      halt_instr      <= 1'b0;
      wake_req        <= 1'b0;
    end else begin
      cnt             <= (kick_en && cnt < KICK - 1) ? cnt + 1 : 0;
      clear_wdt_instr <= clr_cmd | (kick_en && cnt == KICK - 1);
      halt_instr      <= halt_cmd;
      wake_req        <= wake_cmd;
    end
  end
endmodule // wdg_core_model

/* File: verification/wdg_ctrl_tb_top.sv */
`timescale 1ns/1ps
module wdg_ctrl_tb_top;
  import wdg_pkg::*;
  localparam int DLY   = 20;
  localparam int DIV   = 2;
  localparam int LIMIT = 20000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic        clear_wdt_instr, halt_instr, wake_req, re;
  logic        sys_reset, pc_sp_clear, sleeping, irq;
  logic        kick_en, clr_cmd, halt_cmd, wake_cmd;
  wdg_flags_t  cause_flags;
  int          mismatches, checks_done, cycles, n;

  wdg_ctrl #(.POR_DLY(DLY), .WDT_DLY(DLY), .SRESET_DLY(10),
    .SLOW_DIV(DIV)) i_wdg_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clear_wdt_instr(clear_wdt_instr),
    .halt_instr(halt_instr), .wake_req(wake_req),
    .sys_reset(sys_reset), .pc_sp_clear(pc_sp_clear),
    .sleeping(sleeping), .cause_flags(cause_flags), .irq(irq));

  wdg_core_model #(.KICK(300)) i_wdg_core_model (.pclk(pclk),
    .presetn(presetn), .kick_en(kick_en), .clr_cmd(clr_cmd),
    .halt_cmd(halt_cmd), .wake_cmd(wake_cmd),
    .clear_wdt_instr(clear_wdt_instr), .halt_instr(halt_instr),
    .wake_req(wake_req));

  // clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    // the slave promises exactly one wait state; the hang guard ends a stall
    chk("wait_states", 2, k);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [11:0] a,
                    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rq);
  endtask

  // one-cycle core pulse through the model
  task automatic core(input bit h);
    @(posedge pclk);
    if (h) halt_cmd <= 1'b1;
    else clr_cmd <= 1'b1;
    @(posedge pclk);
    halt_cmd <= 1'b0;
    clr_cmd <= 1'b0;
  endtask

  // 0: reset high, 1: reset low, else sleep-clear pulse
  task automatic wait_for(input int which, input int lim);
    bit hit;
    hit = 0;
    n = 0;
    while (!hit && n < lim) begin
      @(posedge pclk);
      n++;
      case (which)
        0: hit = (sys_reset === 1'b1);
        1: hit = (sys_reset === 1'b0);
        default: hit = (pc_sp_clear === 1'b1);
      endcase
    end
  endtask

  task automatic t_reset_values();
    rd("ctrl", ADDR_CTRL, 32'h53);
    rd("rcf", ADDR_RCF, 32'h0);
    rd("stat", ADDR_STAT, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk("slverr", 1, {31'h0, re});
    chk("unmapped", 0, rq);
    apb(1'b1, ADDR_INT_MASK, 32'h7);
    $display("test reset_values done");
  endtask

  task automatic t_kick();
    apb(1'b1, ADDR_CTRL, 32'h50);
    kick_en <= 1'b1;
    wait_for(0, 1500);
    chk("kept_alive", 1500, n);
    kick_en <= 1'b0;
    $display("test kick done");
  endtask

  task automatic t_disable();
    apb(1'b1, ADDR_CTRL, {24'h0, KEY_DISABLE, 3'h0});
    core(0);
    wait_for(0, 1200);
    chk("disabled", 1200, n);
    $display("test disable done");
  endtask

  task automatic t_bad_key();
    apb(1'b1, ADDR_INT_MASK, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h03);
    wait_for(0, 100);
    chk("key_delay", 1, n >= 8 && n <= 16);
    chk("flag_key", 1, {31'h0, cause_flags.key_reset});
    rd("rcf_set", ADDR_RCF, 32'h1);
    rd("int_key", ADDR_INT_STAT, 32'h4);
    chk("masked", 0, {31'h0, irq});
    rd("to_kept", ADDR_STAT, 32'h0);
    wait_for(1, 100);
    apb(1'b1, ADDR_INT_MASK, 32'h7);
    repeat (2) @(posedge pclk);
    chk("irq_on", 1, {31'h0, irq});
    apb(1'b1, ADDR_INT_STAT, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq_off", 0, {31'h0, irq});
    $display("test bad_key done");
  endtask

  task automatic t_run_ovf();
    int exp;
    int c0;
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, ADDR_CTRL, {24'h0, KEY_ENABLE, s[2:0]});
      core(0);
      exp = DIV << (8 + s);
      wait_for(0, 3000);
      // mark the first cycle seen in reset to time the whole hold
      c0 = cycles;
      chk("ovf_time", 1, n >= exp - 4 && n <= exp + 12);
      chk("flags", 1, {31'h0, cause_flags.timeout});
      rd("stat", ADDR_STAT, 32'h1);
      rd("reload", ADDR_CTRL, 32'h53);
      rd("rcf_kept", ADDR_RCF, 32'h1);
      rd("int_run", ADDR_INT_STAT, 32'h1);
      chk("irq", 1, {31'h0, irq});
      wait_for(1, 100);
      chk("hold", DLY, cycles - c0);
      apb(1'b1, ADDR_INT_STAT, 32'h1);
    end
    apb(1'b1, ADDR_RCF, 32'h1);
    rd("rcf_w1", ADDR_RCF, 32'h1);
    apb(1'b1, ADDR_RCF, 32'h0);
    rd("rcf_w0", ADDR_RCF, 32'h0);
    $display("test run_ovf done");
  endtask

  task automatic t_sleep();
    apb(1'b1, ADDR_CTRL, 32'h50);
    core(1);
    repeat (2) @(posedge pclk);
    chk("sleeping", 1, {31'h0, sleeping});
    rd("pd_set", ADDR_STAT, 32'h2);
    wait_for(2, 1000);
    chk("sleep_ovf", 1, n >= 490 && n <= 530);
    @(posedge pclk);
    chk("no_full", 0, {31'h0, sys_reset});
    rd("stat", ADDR_STAT, 32'h3);
    chk("cause", 32'h3, {29'h0, cause_flags});
    rd("ctrl_kept", ADDR_CTRL, 32'h50);
    rd("int_slp", ADDR_INT_STAT, 32'h2);
    core(0);
    repeat (2) @(posedge pclk);
    rd("pd_clr", ADDR_STAT, 32'h0);
    $display("test sleep done");
  endtask

  // halt, then a non-watchdog wake; powerdown must survive the wake
  task automatic t_wake();
    core(1);
    @(posedge pclk);
    wake_cmd <= 1'b1;
    @(posedge pclk);
    wake_cmd <= 1'b0;
    chk("asleep", 1, {31'h0, sleeping});
    repeat (3) @(posedge pclk);
    chk("woken", 0, {31'h0, sleeping});
    chk("pd_kept", 1, {31'h0, cause_flags.powerdown});
    $display("test wake done");
  endtask

  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; kick_en = 1'b0;
    clr_cmd = 1'b0; halt_cmd = 1'b0; wake_cmd = 1'b0;
    mismatches = 0; checks_done = 0; cycles = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wait_for(1, 100);
    t_reset_values();
    t_kick();
    t_disable();
    t_bad_key();
    t_run_ovf();
    t_sleep();
    t_wake();
    report_and_stop();
  end
endmodule // wdg_ctrl_tb_top
